// >>> loop_code_pkg.sv
package loop_code_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // loop code selections
   typedef enum logic [2:0] {
      CODE_NONE      = 3'h0,  // cancels any active code
      CODE_LINE_UP   = 3'h1,  // repeats 10000
      CODE_LINE_DOWN = 3'h2,  // repeats 100
      CODE_4_UP      = 3'h3,  // repeats 1100
      CODE_4_DOWN    = 3'h4,  // repeats 1110
      CODE_5_UP      = 3'h5,  // repeats 11000
      CODE_5_DOWN    = 3'h6   // repeats 11100
   } code_sel_t;

   // one repeating code: length and bits, first sent bit is bits[len-1]
   typedef struct packed {
      logic [2:0] len;
      logic [4:0] bits;
      logic       up;         // loop-up code
   } code_t;

   // code bit display: one digit per position, dash flag wins over digit
   localparam int DISP_W = 16;        // display holds 16 positions
   typedef struct packed {
      logic [DISP_W-1:0] dash;         // position shows a dash
      logic [DISP_W-1:0] bits;         // digit shown where not dashed
   } disp_t;

   // pattern table
   localparam logic [4:0] BITS_LINE_UP   = 5'h10;   // 10000
   localparam logic [4:0] BITS_LINE_DOWN = 5'h04;   // 100
   localparam logic [4:0] BITS_4_UP      = 5'h0C;   // 1100
   localparam logic [4:0] BITS_4_DOWN    = 5'h0E;   // 1110
   localparam logic [4:0] BITS_5_UP      = 5'h18;   // 11000
   localparam logic [4:0] BITS_5_DOWN    = 5'h1C;   // 11100
   localparam logic [2:0] LEN_3          = 3'h3;
   localparam logic [2:0] LEN_4          = 3'h4;
   localparam logic [2:0] LEN_5          = 3'h5;

   // received history window, a multiple of 3 and 5 and above 2x4
   localparam int HIST_W = 15;

   // reset values and buffer full level
   localparam logic [DISP_W-1:0] DASH_ALL  = 16'hFFFF;
   localparam logic [DISP_W-1:0] BITS_ZERO = 16'h0000;
   localparam logic [2:0]        PHASE_RST = 3'h0;
   localparam logic [1:0]        OCC_RST   = 2'h0;
   localparam logic [1:0]        OCC_FULL  = 2'h2;

   // bit layout of a selected code for lookup
   function automatic code_t code_of(input code_sel_t sel);
      code_t c;
      c = '{len: LEN_3, bits: 5'h00, up: 1'b0};
      case (sel)
         CODE_LINE_UP:   c = '{len: LEN_5, bits: BITS_LINE_UP,   up: 1'b1};
         CODE_LINE_DOWN: c = '{len: LEN_3, bits: BITS_LINE_DOWN, up: 1'b0};
         CODE_4_UP:      c = '{len: LEN_4, bits: BITS_4_UP,      up: 1'b1};
         CODE_4_DOWN:    c = '{len: LEN_4, bits: BITS_4_DOWN,    up: 1'b0};
         CODE_5_UP:      c = '{len: LEN_5, bits: BITS_5_UP,      up: 1'b1};
         CODE_5_DOWN:    c = '{len: LEN_5, bits: BITS_5_DOWN,    up: 1'b0};
         default:        c = '{len: LEN_3, bits: 5'h00, up: 1'b0};
      endcase
      return c;
   endfunction : code_of

endpackage : loop_code_pkg

// >>> two_entry_buffer.sv
`timescale 1ns/1ps
`default_nettype none

// two-entry buffer, head word always sits in out_data's flop
module two_entry_buffer
(
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic clk_en,
   // fill side
   input  wire logic in_valid,
   input  wire logic in_data,
   output var  logic in_ready,
   // drain side
   output var  logic out_valid,
   output var  logic out_data,
   input  wire logic out_ready
);

   logic slot1_valid_q;   // second entry occupied
   logic slot1_data_q;    // second entry word

   wire push = in_valid && in_ready;
   wire pop  = out_valid && out_ready;

   ////////////////////////////////////////////////////////////////////////////
   // occupancy and shifting
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         out_valid     <= 1'b0;
         out_data      <= 1'b0;
         slot1_valid_q <= 1'b0;
         slot1_data_q  <= 1'b0;
         in_ready      <= 1'b1;
      end
      else if (clk_en)
      begin
         if (pop)
         begin
            // head leaves: second entry or new word moves up
            out_valid     <= slot1_valid_q || push;
            out_data      <= slot1_valid_q ? slot1_data_q : in_data;
            slot1_valid_q <= slot1_valid_q && push;
            slot1_data_q  <= in_data;
            in_ready      <= 1'b1;
         end
         else if (push)
         begin
            // fill the first free entry
            if (!out_valid)
            begin
               out_valid <= 1'b1;
               out_data  <= in_data;
            end
            else
            begin
               slot1_valid_q <= 1'b1;
               slot1_data_q  <= in_data;
               in_ready      <= 1'b0;
            end
         end
      end
   end

endmodule : two_entry_buffer

`default_nettype wire

// >>> loop_code_gen.sv
`timescale 1ns/1ps
`default_nettype none

module loop_code_gen
(
   // clock, reset, enable
   input  wire logic                       clk,
   input  wire logic                       reset,
   input  wire logic                       clk_en,
   // operator selection
   input  wire logic                       split_access_mode,
   input  wire logic                       sel_valid,
   input  wire loop_code_pkg::code_sel_t   sel_code,
   output logic                            sel_refused,
   output loop_code_pkg::disp_t            code_disp,
   output logic                            loop_active,
   output logic                            loop_done,
   // test pattern source
   input  wire logic                       pat_valid,
   input  wire logic                       pat_data,
   output logic                            pat_ready,
   // line transmit side
   output logic                            tx_valid,
   output logic                            tx_data,
   input  wire logic                       tx_ready,
   // line receive pins, asynchronous
   input  wire logic                       rx_pin_data,
   input  wire logic                       rx_pin_strobe
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   typedef enum logic [3:0] {
      ST_IDLE      = 4'b0001,   // test pattern flows
      ST_SEND_UP   = 4'b0010,   // loop-up code, waiting for echo
      ST_DOWN_WAIT = 4'b0100,   // loop-down code, echo not yet seen
      ST_DOWN_ECHO = 4'b1000    // loop-down code, echo being seen
   } state_t;

   state_t                     state_q;       // controller state
   state_t                     state_d;
   loop_code_pkg::code_t       code_q;        // code being sent
   logic [2:0]                 phase_q;       // bit position in code
   logic [1:0]                 sync_data_q;   // rx data synchroniser
   logic [2:0]                 sync_strb_q;   // rx strobe sync plus edge flop
   logic [loop_code_pkg::HIST_W-1:0] hist_q;  // received bits, newest at 0
   logic [1:0]                 occ_q;         // buffer occupancy mirror
   logic                       room_q;        // buffer has room this cycle
   logic                       buf_in_ready;  // buffer's own ready

   ////////////////////////////////////////////////////////////////////////////
   // echo detector: history is periodic copy of code at some phase
   function automatic logic echo_match(input logic [loop_code_pkg::HIST_W-1:0] h,
                                       input loop_code_pkg::code_t c);
      logic hit;
      logic ok;
      int   p;
      int   i;
      hit = 1'b0;
      for (p = 0; p < 5; p++)
      begin
         ok = (p < int'(c.len));
         for (i = 0; i < loop_code_pkg::HIST_W; i++)
         begin
            if (ok && (h[i] != c.bits[(p + i) % int'(c.len)]))
               ok = 1'b0;
         end
         hit = hit || ok;
      end
      return hit;
   endfunction : echo_match

   // display word for a code, digits left aligned, rest dashed
   function automatic loop_code_pkg::disp_t disp_of(input loop_code_pkg::code_t c);
      loop_code_pkg::disp_t d;
      int k;
      d.dash = loop_code_pkg::DASH_ALL;
      d.bits = loop_code_pkg::BITS_ZERO;
      for (k = 0; k < 5; k++)
      begin
         if (k < int'(c.len))
         begin
            d.dash[loop_code_pkg::DISP_W-1-k] = 1'b0;
            d.bits[loop_code_pkg::DISP_W-1-k] = c.bits[int'(c.len)-1-k];
         end
      end
      return d;
   endfunction : disp_of

   ////////////////////////////////////////////////////////////////////////////
   // selection decode
   wire                  sel_take    = sel_valid && split_access_mode;
   wire                  sel_reject  = sel_valid && !split_access_mode;
   wire                  sel_none    = sel_code == loop_code_pkg::CODE_NONE;
   wire loop_code_pkg::code_t sel_c  = loop_code_pkg::code_of(sel_code);
   wire                  sending     = state_q != ST_IDLE;

   // receive side
   wire                  rx_edge     = sync_strb_q[1] && !sync_strb_q[2];
   wire                  echo_now    = echo_match(hist_q, code_q);
   wire                  echo_gone   = (state_q == ST_DOWN_ECHO) && !echo_now;
   wire                  echo_up     = (state_q == ST_SEND_UP) && echo_now;
   wire                  finish      = echo_gone || echo_up;

   // transmit source selection
   wire                  code_bit    = code_q.bits[3'(code_q.len - 3'h1 - phase_q)];
   wire                  code_push   = sending && room_q && buf_in_ready;
   wire                  pat_push    = pat_valid && pat_ready && buf_in_ready;
   wire                  buf_push    = code_push || pat_push;
   wire                  buf_wdata   = sending ? code_bit : pat_data;
   wire                  buf_pop     = tx_valid && tx_ready;
   wire [1:0]            occ_d       = 2'(occ_q + {1'b0, buf_push} - {1'b0, buf_pop});
   wire                  room_d      = occ_d != loop_code_pkg::OCC_FULL;
   wire [2:0]            phase_wrap  = (phase_q == 3'(code_q.len - 3'h1)) ? loop_code_pkg::PHASE_RST
                                                                         : 3'(phase_q + 3'h1);

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            state_d = ST_IDLE;
         ST_SEND_UP:
            if (echo_up)
               state_d = ST_IDLE;
         ST_DOWN_WAIT:
            if (echo_now)
               state_d = ST_DOWN_ECHO;
         ST_DOWN_ECHO:
            if (echo_gone)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
      // a taken selection overrides the running sequence
      if (sel_take)
      begin
         if (sel_none)
            state_d = ST_IDLE;
         else if (sel_c.up)
            state_d = ST_SEND_UP;
         else
            state_d = ST_DOWN_WAIT;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state and code registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_q <= ST_IDLE;
         code_q  <= '{len: loop_code_pkg::LEN_3, bits: 5'h00, up: 1'b0};
         phase_q <= loop_code_pkg::PHASE_RST;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         if (sel_take && !sel_none)
         begin
            code_q  <= sel_c;
            phase_q <= loop_code_pkg::PHASE_RST;
         end
         else if (code_push)
            phase_q <= phase_wrap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operator outputs
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sel_refused    <= 1'b0;
         code_disp.dash <= loop_code_pkg::DASH_ALL;
         code_disp.bits <= loop_code_pkg::BITS_ZERO;
         loop_active    <= 1'b0;
         loop_done      <= 1'b0;
      end
      else if (clk_en)
      begin
         sel_refused <= sel_reject;
         if (sel_take && sel_none)
         begin
            code_disp.dash <= loop_code_pkg::DASH_ALL;
            code_disp.bits <= loop_code_pkg::BITS_ZERO;
         end
         else if (sel_take)
            code_disp <= disp_of(sel_c);
         loop_active <= state_d != ST_IDLE;
         loop_done   <= finish && !sel_take;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive synchroniser and history
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         sync_data_q <= 2'h0;
         sync_strb_q <= 3'h0;
         hist_q      <= 15'h0000;
      end
      else if (clk_en)
      begin
         sync_data_q <= {sync_data_q[0], rx_pin_data};
         sync_strb_q <= {sync_strb_q[1:0], rx_pin_strobe};
         if (rx_edge)
            hist_q <= {hist_q[loop_code_pkg::HIST_W-2:0], sync_data_q[1]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // buffer occupancy mirror and registered pattern ready
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         occ_q     <= loop_code_pkg::OCC_RST;
         room_q    <= 1'b1;
         pat_ready <= 1'b0;
      end
      else if (clk_en)
      begin
         occ_q     <= occ_d;
         room_q    <= room_d;
         pat_ready <= room_d && (state_d == ST_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit buffer
   two_entry_buffer u_tx_buffer
   (
      .clk       (clk),
      .reset     (reset),
      .clk_en    (clk_en),
      .in_valid  (buf_push),
      .in_data   (buf_wdata),
      .in_ready  (buf_in_ready),
      .out_valid (tx_valid),
      .out_data  (tx_data),
      .out_ready (tx_ready)
   );

endmodule : loop_code_gen

`default_nettype wire

// >>> loop_code_gen_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// port checker for the loop code generator
module loop_code_gen_asserts
(
   // clock and reset
   input wire logic                     clk,
   input wire logic                     reset,
   input wire logic                     clk_en,
   // selection
   input wire logic                     split_access_mode,
   input wire logic                     sel_valid,
   input wire loop_code_pkg::code_sel_t sel_code,
   input wire logic                     sel_refused,
   input wire loop_code_pkg::disp_t     code_disp,
   input wire logic                     loop_active,
   input wire logic                     loop_done,
   // line transmit
   input wire logic                     tx_valid,
   input wire logic                     tx_data,
   input wire logic                     tx_ready
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   ////////////////////////////////////////////////////////////////////////////
   wire take = clk_en && sel_valid && split_access_mode;  // accepted selection
   wire deny = clk_en && sel_valid && !split_access_mode; // refused selection

   // expected display as {dash, bits}
   function automatic logic [31:0] disp_exp(input logic [2:0] c);
      case (c)
         3'h1:    return 32'h07FF_8000;
         3'h2:    return 32'h1FFF_8000;
         3'h3:    return 32'h0FFF_C000;
         3'h4:    return 32'h0FFF_E000;
         3'h5:    return 32'h07FF_C000;
         3'h6:    return 32'h07FF_E000;
         default: return 32'hFFFF_0000;
      endcase
   endfunction : disp_exp

   ////////////////////////////////////////////////////////////////////////////
   property p_refuse; deny |=> sel_refused; endproperty
   a_refuse: assert property (p_refuse) else $error("refused pick gave no pulse");
   property p_refuse_why; sel_refused |-> $past(deny); endproperty
   a_refuse_why: assert property (p_refuse_why) else $error("refusal pulse without cause");
   property p_refuse_hold; deny |=> $stable(code_disp) && $stable(loop_active); endproperty
   a_refuse_hold: assert property (p_refuse_hold) else $error("refused pick changed state");
   property p_disp; take && sel_code != 3'h7 |=> code_disp == disp_exp($past(sel_code)); endproperty
   a_disp: assert property (p_disp) else $error("display wrong after pick");
   property p_start; take && sel_code inside {[3'h1:3'h6]} |=> loop_active; endproperty
   a_start: assert property (p_start) else $error("code not started");
   property p_none; take && sel_code == loop_code_pkg::CODE_NONE |=> !loop_active && !loop_done; endproperty
   a_none: assert property (p_none) else $error("none left code running");
   property p_done; loop_done |-> !loop_active && $past(loop_active) ##1 !loop_done; endproperty
   a_done: assert property (p_done) else $error("bad end of code");
   property p_tx_hold; tx_valid && !tx_ready && clk_en |=> tx_valid && $stable(tx_data); endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("stalled word lost");

   // main scenarios reached
   c_refuse: cover property (deny);
   c_done: cover property (loop_done);
   c_stall: cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
endmodule : loop_code_gen_asserts

bind loop_code_gen loop_code_gen_asserts chk_u (.clk(clk), .reset(reset), .clk_en(clk_en),
   .split_access_mode(split_access_mode), .sel_valid(sel_valid), .sel_code(sel_code),
   .sel_refused(sel_refused), .code_disp(code_disp), .loop_active(loop_active),
   .loop_done(loop_done), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

`default_nettype wire

// >>> line_partner.sv
`timescale 1ns/1ps
`default_nettype none

// remote line: takes sent bits, loops them back when echo_on
module line_partner
(
   // clock and reset
   input wire logic  clk,
   input wire logic  reset,
   // bench controls
   input wire logic  echo_on,
   input wire logic  slow,
   // line side
   input wire logic  tx_valid,
   input wire logic  tx_data,
   output var logic  tx_ready,
   output var logic  rx_pin_data,
   output var logic  rx_pin_strobe
);
   logic       q [$];           // bits waiting to be looped back
   logic [2:0] ph_q = 3'h0;     // eight clocks per received bit
   logic [1:0] st_q = 2'h0;     // stall pacing

   // half-rate acceptance while slow
   assign tx_ready = !slow || st_q[1];

   // strobe low four clocks, high four, data set while low
   always @(posedge clk)
   begin
      if (reset)
      begin
         ph_q <= 3'h0;
         rx_pin_strobe <= 1'b0;
         rx_pin_data <= 1'b1;
         q.delete();
      end
      else
      begin
         st_q <= st_q + 2'h1;
         ph_q <= ph_q + 3'h1;
         if (!echo_on)
            q.delete();
         else if (tx_valid && tx_ready)
            q.push_back(tx_data);
         if (ph_q == 3'h0)
         begin
            rx_pin_strobe <= 1'b0;
            rx_pin_data <= (q.size() > 0) ? q.pop_front() : 1'b1;
         end
         if (ph_q == 3'h4)
            rx_pin_strobe <= 1'b1;
      end
   end
endmodule : line_partner

`default_nettype wire

// >>> loop_code_gen_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
   begin \
      n_compared++; \
      if ((g) !== (e)) \
      begin \
         mismatches++; \
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
      end \
   end

module loop_code_gen_tb_top;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic split_access_mode = 1'b1;
   logic sel_valid = 1'b0;
   loop_code_pkg::code_sel_t sel_code = loop_code_pkg::CODE_NONE;
   logic pat_valid = 1'b0;
   logic pat_data = 1'b0;
   logic echo_on = 1'b0;
   logic slow = 1'b0;
   logic sel_refused, loop_active, loop_done, pat_ready, tx_valid, tx_data, tx_ready, rx_d, rx_s;
   loop_code_pkg::disp_t code_disp;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [4:0] eb [0:6] = '{5'h00, 5'h10, 5'h04, 5'h0C, 5'h0E, 5'h18, 5'h1C}; // code bits
   int         el [0:6] = '{3, 5, 3, 4, 4, 5, 5};                            // code lengths

   always #12.5 clk = ~clk;

   loop_code_gen dut_u (.clk(clk), .reset(reset), .clk_en(clk_en), .split_access_mode(split_access_mode),
      .sel_valid(sel_valid), .sel_code(sel_code), .sel_refused(sel_refused), .code_disp(code_disp),
      .loop_active(loop_active), .loop_done(loop_done), .pat_valid(pat_valid), .pat_data(pat_data),
      .pat_ready(pat_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .rx_pin_data(rx_d), .rx_pin_strobe(rx_s));
   line_partner line_u (.clk(clk), .reset(reset), .echo_on(echo_on), .slow(slow), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .rx_pin_data(rx_d), .rx_pin_strobe(rx_s));

   ////////////////////////////////////////////////////////////////////////////
   // one selection pulse, returns just after the answering edge
   task automatic pick(input logic [2:0] c);
      @(posedge clk);
      sel_valid <= 1'b1;
      sel_code <= loop_code_pkg::code_sel_t'(c);
      @(posedge clk);
      sel_valid <= 1'b0;
      #1;
   endtask : pick

   // cancel and let the buffer empty
   task automatic drain();
      int n;
      pick(3'h0);
      `CHK(code_disp, 32'hFFFF_0000)
      `CHK(loop_active, 1'b0)
      for (n = 0; n < 30 && tx_valid; n++)
      begin
         @(posedge clk);
         #1;
      end
      `CHK(tx_valid, 1'b0)
   endtask : drain

   // wait for the end pulse
   task automatic hunt(input int lim, output logic seen);
      seen = 1'b0;
      repeat (lim) if (!seen)
      begin
         @(posedge clk);
         #1;
         seen = loop_done;
      end
   endtask : hunt

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_refuse();
      @(posedge clk);
      split_access_mode <= 1'b0;
      pick(3'h3);
      `CHK(sel_refused, 1'b1)
      `CHK(code_disp, 32'hFFFF_0000)
      `CHK(loop_active, 1'b0)
      @(posedge clk);
      split_access_mode <= 1'b1;
   endtask : t_refuse

   // enable low freezes a running code and ignores a pick
   task automatic t_freeze();
      logic d;
      pick(3'h3);
      repeat (3) @(posedge clk);
      clk_en <= 1'b0;
      @(posedge clk);
      #1;
      d = tx_data;
      pick(3'h0);
      repeat (4) @(posedge clk);
      #1;
      `CHK(tx_valid, 1'b1)
      `CHK(tx_data, d)
      `CHK(loop_active, 1'b1)
      `CHK(code_disp, 32'h0FFF_C000)
      @(posedge clk);
      clk_en <= 1'b1;
   endtask : t_freeze

   // every code, odd ones with a stalling line
   task automatic t_codes();
      int c, i;
      logic [15:0] b;
      for (c = 1; c < 7; c++)
      begin
         drain();
         @(posedge clk);
         slow <= c[0];
         pick(c[2:0]);
         b = 16'(eb[c]) << (16 - el[c]);
         `CHK(code_disp, {16'hFFFF >> el[c], b})
         `CHK(loop_active, 1'b1)
         i = 0;
         repeat (60)
         begin
            if (tx_valid && tx_ready && i < 12)
            begin
               `CHK(tx_data, eb[c][el[c] - 1 - i % el[c]])
               i++;
            end
            @(posedge clk);
            #1;
         end
         `CHK(i, 12)
      end
   endtask : t_codes

   task automatic t_loop_down();
      logic seen;
      drain();
      @(posedge clk);
      slow <= 1'b0;
      echo_on <= 1'b1;
      pick(3'h2);
      hunt(250, seen);
      `CHK(seen, 1'b0)
      `CHK(loop_active, 1'b1)
      @(posedge clk);
      echo_on <= 1'b0;
      hunt(200, seen);
      `CHK(seen, 1'b1)
      `CHK(loop_active, 1'b0)
   endtask : t_loop_down

   task automatic t_loop_up();
      logic seen;
      drain();
      @(posedge clk);
      echo_on <= 1'b1;
      pick(3'h5);
      hunt(400, seen);
      `CHK(seen, 1'b1)
      `CHK(loop_active, 1'b0)
      @(posedge clk);
      echo_on <= 1'b0;
      pat_valid <= 1'b1;
      pat_data <= 1'b1;
      repeat (12) @(posedge clk);
      #1;
      `CHK(pat_ready, 1'b1)
      `CHK(tx_valid, 1'b1)
      `CHK(tx_data, 1'b1)
   endtask : t_loop_up

   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         give_verdict();
      end
   end

   // main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      t_refuse();
      t_freeze();
      t_codes();
      t_loop_down();
      t_loop_up();
      give_verdict();
   end
endmodule : loop_code_gen_tb_top

`default_nettype wire
